// *** shared/wdt_defines.svh ***
// constants for the watchdog and sleep/wake control block
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ---------------------------------------------------------------
// register map (byte addresses, one register every 4 bytes)
// ---------------------------------------------------------------
`define ADDR_WDOG_CTRL 8'h00
`define ADDR_TMR_OPT 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CMD 8'h0C
`define ADDR_CFG 8'h10
`define ADDR_IRQ 8'h14

// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define WDOG_CTRL_RST 8'h08
`define TMR_OPT_RST 8'hFF
`define WPS_LSB 1
`define WPS_MAX 4'hB
`define OPT_PSA_BIT 3
`define CMD_CLEAR_WATCHDOG_INSTR_BIT 0
`define CMD_SLEEP_BIT 1
`define CMD_OSCFAIL_BIT 2
`define CMD_SERVICE_BIT 3
`define CMD_RETFIE_BIT 4
`define IRQ_VECTOR 11'h004

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LFOSC_HZ 31000
`define SYS_CLK_HZ 125000000
`define LF_DIV_CNT (`SYS_CLK_HZ / `LFOSC_HZ)
`define OST_PERIODS 1024
`define WDOG_PRE_BITS 16
`define WDOG_BASE_SHIFT 5

`endif

// *** shared/wdt_pkg.sv ***
// types for the watchdog and sleep/wake control block
package wdt_pkg;

  // clock source modes
  typedef enum logic [2:0] {
    CLK_LP = 3'h0, CLK_XT = 3'h1, CLK_HS = 3'h2, CLK_EC = 3'h3,
    CLK_INTOSC = 3'h4, CLK_RC = 3'h5
  } clk_mode_t;

  // power state, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_OST = 3'b100
  } pwr_state_t;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // wake outcome
  typedef struct packed {
    logic woke;
    logic vector;
    logic reset;
  } wake_t;

endpackage

// *** core/wdt_counter.sv ***
// watchdog ripple counter stepped by the low-frequency tick
`timescale 1ns/1ps
`include "wdt_defines.svh"
module wdt_counter
  import wdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic run,
  input wire logic [3:0] period_sel,
  input wire logic use_shared,
  input wire logic [2:0] shared_rate,
  output logic [23:0] count,
  output logic expire
);

  logic [23:0] count_r;
  logic [4:0] tap;
  logic [5:0] sel_sum;

  // tap = base (1:32) + period code, plus shared prescaler (1:1..1:128)
  assign sel_sum = 6'(`WDOG_BASE_SHIFT) + {2'h0, period_sel}
                   + (use_shared ? {3'h0, shared_rate} : 6'h00);
  assign tap = (sel_sum > 6'h17) ? 5'h17 : sel_sum[4:0];
  assign count = count_r;
  assign expire = run && tick && (count_r[tap] == 1'b1);

  // counter clears on request or expiry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 24'h000000;
    end else if (clear || expire) begin
      count_r <= 24'h000000;
    end else if (run && tick) begin
      count_r <= count_r + 24'h000001;
    end
  end

endmodule

// *** core/wdt_sleep_ctrl.sv ***
// watchdog timer, sleep entry and wake-up control
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "wdt_defines.svh"
// What this block does
// - watchdog ticks only from low-frequency oscillator
// - sixteen-bit watchdog prescaler before time-out
// - shared eight-bit prescaler usable when assigned
// - period selectable from milliseconds to minutes
// - reset loads 1:512, software enable off
// - start-up timer holds watchdog in reset
// - 1024-period start-up only crystal modes
// - configuration enable forces watchdog always on
// - software bit enables watchdog when config clear
// - period codes 1:32 to 1:65536, rest reserved
// - crystal wake keeps watchdog cleared until start-up
// - sleep clears watchdog and powerdown flag, sets timeout flag, stops oscillator
// - watchdog reset never drives master clear
// - master clear during sleep resets; other wake events continue execution
// - timeout flag cleared on watchdog time-out, powerdown on sleep
// - only clockless sources wake from sleep
// - individual enable alone permits wake
// - after wake run next, vector if global enable
// - pending enabled flag with global enable clear makes sleep a no-op
// - interrupt during sleep wakes immediately, flags updated
// - every wake from sleep clears watchdog
// - interrupt saves only return address
// - global enable cleared on reset and service
module wdt_sleep_ctrl
  import wdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic config_watchdog_enable,
  input wire logic [2:0] clk_mode,
  input wire logic master_clear_pin,
  input wire logic [6:0] wake_src_pend,
  input wire logic [10:0] return_pc,
  output logic [7:0] reg_rdata,
  output logic watchdog_reset,
  output logic osc_driver_on,
  output logic io_hold,
  output logic sleeping,
  output logic resume_pulse,
  output logic vector_pulse,
  output logic [10:0] vector_addr,
  output logic [10:0] saved_pc,
  output logic master_clear_oe
);

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  reg_req_t req;
  pwr_state_t state_r, state_nxt;
  logic [7:0] wdog_ctrl_r;
  logic [7:0] tmr_opt_r;
  logic [6:0] irq_en_r;
  logic gie_r, gie_nxt;
  logic timeout_flag_r, timeout_flag_nxt;
  logic powerdown_flag_r, powerdown_flag_nxt;
  logic [7:0] reg_rdata_r;
  logic wdog_reset_r, osc_on_r, hold_r, resume_r, vector_r, pend_vec_r;
  logic [10:0] saved_pc_r;
  logic [15:0] lf_div_r;
  logic [10:0] ost_cnt_r;
  logic master_clear_pin_s1_r, master_clear_pin_s2_r;
  logic [6:0] src_s1_r, src_s2_r;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_s1_r <= 1'b1;
      master_clear_pin_s2_r <= 1'b1;
      src_s1_r <= 7'h00;
      src_s2_r <= 7'h00;
    end else begin
      master_clear_pin_s1_r <= master_clear_pin;
      master_clear_pin_s2_r <= master_clear_pin_s1_r;
      src_s1_r <= wake_src_pend;
      src_s2_r <= src_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr_ctrl = req.wr && (req.addr == `ADDR_WDOG_CTRL);
  wire wr_opt = req.wr && (req.addr == `ADDR_TMR_OPT);
  wire wr_cmd = req.wr && (req.addr == `ADDR_CMD);
  wire wr_irq = req.wr && (req.addr == `ADDR_IRQ);
  wire cmd_clear_watchdog_instr = wr_cmd && req.wdata[`CMD_CLEAR_WATCHDOG_INSTR_BIT];
  wire cmd_sleep = wr_cmd && req.wdata[`CMD_SLEEP_BIT];
  wire cmd_oscfail = wr_cmd && req.wdata[`CMD_OSCFAIL_BIT];
  wire cmd_service = wr_cmd && req.wdata[`CMD_SERVICE_BIT];
  wire cmd_retfie = wr_cmd && req.wdata[`CMD_RETFIE_BIT];
  wire [3:0] wps_field = req.wdata[`WPS_LSB +: 4];
  wire crystal_mode = (clk_mode == CLK_LP) || (clk_mode == CLK_XT)
                      || (clk_mode == CLK_HS);
  wire wake_pending = |(src_s2_r & irq_en_r);
  wire master_clear_pin_active = !master_clear_pin_s2_r;

  // ---------------------------------------------------------------
  // low-frequency tick, ~31 kHz enable pulse
  // ---------------------------------------------------------------
  wire lf_tick = (lf_div_r == 16'(`LF_DIV_CNT - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lf_div_r <= 16'h0000;
    end else begin
      lf_div_r <= lf_tick ? 16'h0000 : lf_div_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // watchdog enable, clear and run
  // ---------------------------------------------------------------
  wire wdog_expire;
  wire wdog_enabled = config_watchdog_enable || wdog_ctrl_r[0];
  wire in_ost = (state_r == ST_OST);
  wire sleep_taken = cmd_sleep && !(wake_pending && !gie_r);
  wire wake_now = (state_r == ST_SLEEP) && (wake_pending || wdog_expire);
  wire wdog_clear = cmd_clear_watchdog_instr || cmd_oscfail
                    || sleep_taken
                    || wake_now || in_ost;
  wire wdog_run = wdog_enabled && !in_ost;

  // ripple counter with 16-bit prescaler and shared 8-bit option
  wdt_counter u_counter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(lf_tick),
    .clear(wdog_clear),
    .run(wdog_run),
    .period_sel(wdog_ctrl_r[`WPS_LSB +: 4]),
    .use_shared(tmr_opt_r[`OPT_PSA_BIT]),
    .shared_rate(tmr_opt_r[2:0]),
    .count(),
    .expire(wdog_expire)
  );

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (sleep_taken) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_now) begin
          state_nxt = crystal_mode ? ST_OST : ST_RUN;
        end
      end
      ST_OST: begin
        if (lf_tick && ost_cnt_r == 11'(`OST_PERIODS - 1)) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // start-up timer shares the watchdog time base
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ost_cnt_r <= 11'h000;
    end else if (!in_ost) begin
      ost_cnt_r <= 11'h000;
    end else if (lf_tick) begin
      ost_cnt_r <= ost_cnt_r + 11'h001;
    end
  end

  // ---------------------------------------------------------------
  // status flags and global enable
  // ---------------------------------------------------------------
  always_comb begin
    timeout_flag_nxt = timeout_flag_r;
    powerdown_flag_nxt = powerdown_flag_r;
    gie_nxt = gie_r;
    if (sleep_taken) begin
      timeout_flag_nxt = 1'b1;
      powerdown_flag_nxt = 1'b0;
    end
    if (wake_now && wdog_expire) begin
      timeout_flag_nxt = 1'b0;
    end else if (wdog_expire && state_r == ST_RUN) begin
      timeout_flag_nxt = 1'b0;
    end
    if (cmd_retfie) begin
      gie_nxt = 1'b1;
    end
    if (wr_irq) begin
      gie_nxt = req.wdata[7];
    end
    if (cmd_service || (resume_r && pend_vec_r)) begin
      gie_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      wdog_ctrl_r <= `WDOG_CTRL_RST;
      tmr_opt_r <= `TMR_OPT_RST;
      irq_en_r <= 7'h00;
      gie_r <= 1'b0;
      timeout_flag_r <= 1'b1;
      powerdown_flag_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (wr_ctrl) begin
        if (wps_field <= `WPS_MAX) begin
          wdog_ctrl_r <= {3'h0, req.wdata[4:0]};
        end else begin
          wdog_ctrl_r <= {3'h0, wdog_ctrl_r[4:1], req.wdata[0]};
        end
      end
      if (wr_opt) begin
        tmr_opt_r <= req.wdata;
      end
      if (wr_irq) begin
        irq_en_r <= req.wdata[6:0];
      end
      gie_r <= gie_nxt;
      timeout_flag_r <= timeout_flag_nxt;
      powerdown_flag_r <= powerdown_flag_nxt;
    end
  end

  // wake results, reset request and pc handling
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_reset_r <= 1'b0;
      osc_on_r <= 1'b1;
      hold_r <= 1'b0;
      resume_r <= 1'b0;
      vector_r <= 1'b0;
      pend_vec_r <= 1'b0;
      saved_pc_r <= 11'h000;
    end else begin
      // time-out in run or sleep-with-master_clear_pin resets internally only
      wdog_reset_r <= (wdog_expire && state_r == ST_RUN)
                      || (master_clear_pin_active && state_r == ST_SLEEP);
      osc_on_r <= (state_nxt != ST_SLEEP);
      hold_r <= (state_nxt == ST_SLEEP);
      resume_r <= (state_r != ST_RUN) && (state_nxt == ST_RUN)
                  && !master_clear_pin_active;
      if (wake_now) begin
        pend_vec_r <= gie_r && wake_pending;
      end else if (resume_r) begin
        pend_vec_r <= 1'b0;
      end
      vector_r <= (resume_r && pend_vec_r) || cmd_service;
      if ((resume_r && pend_vec_r) || cmd_service) begin
        saved_pc_r <= return_pc;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port, data one cycle after strobe
  // ---------------------------------------------------------------
  wire [7:0] status_word = {3'h0, (state_r == ST_SLEEP), in_ost,
                            gie_r, timeout_flag_r, powerdown_flag_r};
  wire [7:0] cfg_word = {4'h0, clk_mode, config_watchdog_enable};
  wire [7:0] rd_mux = (req.addr == `ADDR_WDOG_CTRL) ? wdog_ctrl_r :
                      (req.addr == `ADDR_TMR_OPT) ? tmr_opt_r :
                      (req.addr == `ADDR_STATUS) ? status_word :
                      (req.addr == `ADDR_CFG) ? cfg_word :
                      (req.addr == `ADDR_IRQ) ? {gie_r, irq_en_r} : 8'h00;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign watchdog_reset = wdog_reset_r;
  assign osc_driver_on = osc_on_r;
  assign io_hold = hold_r;
  assign sleeping = hold_r;
  assign resume_pulse = resume_r;
  assign vector_pulse = vector_r;
  assign vector_addr = `IRQ_VECTOR;  // constant vector
  assign saved_pc = saved_pc_r;
  assign master_clear_oe = 1'b0;

endmodule

// *** sim/wdt_sleep_ctrl_chk.sv ***
// port checker for the watchdog and sleep/wake control block
`timescale 1ns/1ps
`include "wdt_defines.svh"
module wdt_sleep_ctrl_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic master_clear_pin,
  input wire logic [6:0] wake_src_pend,
  input wire logic [7:0] reg_rdata,
  input wire logic watchdog_reset,
  input wire logic osc_driver_on,
  input wire logic io_hold,
  input wire logic sleeping,
  input wire logic resume_pulse,
  input wire logic vector_pulse,
  input wire logic [10:0] vector_addr,
  input wire logic master_clear_oe
);
  // ---------------------------------------------
  // one clock domain, reset disables all checks
  // ---------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_master_clear_pin_undriven: assert property (master_clear_oe == 1'b0)
    else $error("master clear pin driven");
  a_vector_addr: assert property (vector_pulse |-> vector_addr == `IRQ_VECTOR)
    else $error("vector address wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  a_ctrl_unused: assert property ($past(reg_rd) && $past(reg_addr) == `ADDR_WDOG_CTRL
    |-> reg_rdata[7:5] == 3'h0)
    else $error("control upper bits set");
  a_sleep_io: assert property (sleeping |-> io_hold && !osc_driver_on)
    else $error("sleep without hold or with oscillator");
  a_sleep_entry: assert property (reg_wr && reg_addr == `ADDR_CMD && reg_wdata[1]
    && !sleeping && wake_src_pend == 7'h00 && $past(wake_src_pend) == 7'h00
    && $past(wake_src_pend, 2) == 7'h00 |-> ##[1:2] sleeping)
    else $error("sleep not entered");
  a_status_sleep: assert property ($past(reg_rd) && $past(reg_addr) == `ADDR_STATUS
    && $past(sleeping) && $past(sleeping, 2) |-> reg_rdata[4])
    else $error("status misses sleep");
  a_reset_no_resume: assert property (watchdog_reset |-> !resume_pulse)
    else $error("resume with reset");
  a_master_clear_pin_wake: assert property (sleeping && $fell(master_clear_pin)
    |-> ##[1:5] watchdog_reset)
    else $error("master clear did not reset");
  a_resume_single: assert property (resume_pulse |=> !resume_pulse)
    else $error("resume longer than one cycle");
endmodule

bind wdt_sleep_ctrl wdt_sleep_ctrl_chk u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .master_clear_pin, .wake_src_pend, .reg_rdata, .watchdog_reset,
  .osc_driver_on, .io_hold, .sleeping, .resume_pulse, .vector_pulse, .vector_addr,
  .master_clear_oe);

// *** sim/watchdog_and_sleep_wake_control_tb.sv ***
// self-checking bench for the watchdog and sleep/wake control block
`timescale 1ns/1ps
`include "wdt_defines.svh"
module watchdog_and_sleep_wake_control_tb
  import wdt_pkg::*;
;
  logic sys_clk, rst_n, reg_wr, reg_rd, config_watchdog_enable, master_clear_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] clk_mode;
  logic [6:0] wake_src_pend;
  logic [10:0] return_pc, vector_addr, saved_pc, n_res, n_vec, n_wdr;
  logic watchdog_reset, osc_driver_on, io_hold, sleeping, resume_pulse, vector_pulse;
  logic master_clear_oe;
  int errors, n_checks, cyc;

  wdt_sleep_ctrl u_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .config_watchdog_enable, .clk_mode, .master_clear_pin, .wake_src_pend, .return_pc,
    .reg_rdata, .watchdog_reset, .osc_driver_on, .io_hold, .sleeping, .resume_pulse,
    .vector_pulse, .vector_addr, .saved_pc, .master_clear_oe);

  // ---------------------------------------------
  // clock, hang limit
  // ---------------------------------------------
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      wrap_up;
    end
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [7:0] exp_ctrl(input logic [7:0] old, w);
    return {3'h0, (w[4:1] > `WPS_MAX) ? old[4:1] : w[4:1], w[0]};
  endfunction
  function automatic logic [7:0] exp_st(input logic s, g, t, p);
    return {3'h0, s, 1'b0, g, t, p};
  endfunction
  task automatic chk(input logic [10:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp, m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({3'h0, reg_rdata & m}, {3'h0, exp & m});
  endtask
  // count output pulses over n cycles, starting with the current one
  task automatic watch(input int n);
    n_res = 0;
    n_vec = 0;
    n_wdr = 0;
    repeat (n) begin
      #1;
      n_res = n_res + resume_pulse;
      n_vec = n_vec + vector_pulse;
      n_wdr = n_wdr + watchdog_reset;
      @(posedge sys_clk);
    end
    #1;
  endtask
  task automatic wrap_up;
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    int k;
    logic [7:0] w, cs;
    errors = 0;
    n_checks = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    config_watchdog_enable = 1'b0;
    clk_mode = CLK_EC;
    master_clear_pin = 1'b1;
    wake_src_pend = 7'h00;
    return_pc = 11'h000;
    rst_n = 1'b0;
    void'($urandom(32'h586B4F1F));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`ADDR_WDOG_CTRL, `WDOG_CTRL_RST, 8'hFF);
    rd(`ADDR_TMR_OPT, `TMR_OPT_RST, 8'hFF);
    rd(`ADDR_STATUS, exp_st(0, 0, 1, 1), 8'hFF);
    rd(`ADDR_IRQ, 8'h00, 8'hFF);
    rd(8'h18, 8'h00, 8'hFF);
    // every clock mode and config enable reach the config view
    for (int m = 0; m < 6; m++) begin
      clk_mode <= m[2:0];
      config_watchdog_enable <= m[0];
      rd(`ADDR_CFG, {4'h0, m[2:0], m[0]}, 8'hFF);
    end
    clk_mode <= CLK_EC;
    config_watchdog_enable <= 1'b0;
    // all period codes, then random writes
    cs = `WDOG_CTRL_RST;
    for (int i = 0; i < 24; i++) begin
      w = (i < 16) ? {3'h0, i[3:0], i[0]} : 8'($urandom);
      wr(`ADDR_WDOG_CTRL, w);
      cs = exp_ctrl(cs, w);
      rd(`ADDR_WDOG_CTRL, cs, 8'hFF);
      w = 8'($urandom);
      wr(`ADDR_TMR_OPT, w);
      rd(`ADDR_TMR_OPT, w, 8'hFF);
      wr(`ADDR_STATUS, w);
      rd(`ADDR_STATUS, exp_st(0, 0, 1, 1), 8'hFF);
    end
    // pending enabled flag with global enable clear: sleep is a no-op
    wr(`ADDR_IRQ, 8'h01);
    wake_src_pend <= 7'h01;
    repeat (4) @(posedge sys_clk);
    wr(`ADDR_CMD, 8'h02);
    watch(3);
    chk(sleeping, 0);
    rd(`ADDR_STATUS, exp_st(0, 0, 1, 1), 8'hFF);
    wake_src_pend <= 7'h00;
    repeat (4) @(posedge sys_clk);
    // interrupt wake with global enable clear, then set
    for (int g = 0; g < 2; g++) begin
      k = $urandom_range(6);
      wr(`ADDR_IRQ, {g[0], 7'(1 << k)});
      wr(`ADDR_CMD, 8'h02);
      watch(2);
      chk({io_hold, osc_driver_on, sleeping}, 3'b101);
      rd(`ADDR_STATUS, exp_st(1, g[0], 1, 0), 8'hFF);
      wake_src_pend <= 7'(1 << ((k + 1) % 7));
      watch(8);
      chk(sleeping, 1);
      wake_src_pend <= 7'(1 << k);
      watch(8);
      chk(n_res, 1);
      chk(n_vec, 11'(g));
      chk(sleeping, 0);
      chk(vector_addr, `IRQ_VECTOR);
      rd(`ADDR_STATUS, exp_st(0, 0, 1, 0), 8'hFF);
      wake_src_pend <= 7'h00;
      repeat (4) @(posedge sys_clk);
    end
    // interrupt service and return
    return_pc <= 11'($urandom);
    wr(`ADDR_IRQ, 8'h80);
    wr(`ADDR_CMD, 8'h08);
    watch(3);
    chk(n_vec, 1);
    chk(saved_pc, return_pc);
    rd(`ADDR_STATUS, exp_st(0, 0, 1, 0), 8'hFF);
    wr(`ADDR_CMD, 8'h10);
    rd(`ADDR_STATUS, exp_st(0, 1, 1, 0), 8'hFF);
    wr(`ADDR_CMD, 8'h05);
    watch(4);
    chk(n_wdr, 0);
    // master clear while asleep
    wr(`ADDR_IRQ, 8'h00);
    wr(`ADDR_CMD, 8'h02);
    watch(2);
    chk(sleeping, 1);
    master_clear_pin <= 1'b0;
    watch(8);
    chk(n_wdr != 0, 1);
    chk(n_res, 0);
    chk(master_clear_oe, 0);
    master_clear_pin <= 1'b1;
    wrap_up;
  end
endmodule
